// [hdl/odrb_decoder.sv]
// decoder for register/memory, relative branch and bit instructions
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`include "odrb_map.svh"
`default_nettype none
module odrb_decoder (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // classic wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // decode request from the fetch unit
  input  wire logic                 dec_req,
  input  wire logic [7:0]           opcode,
  input  wire logic [7:0]           operand1,
  input  wire logic [7:0]           operand2,
  input  wire logic [7:0]           index_reg,
  input  wire logic [7:0]           mem_byte,
  input  wire logic                 ccr_c,
  input  wire logic                 ccr_z,
  input  wire logic                 ccr_n,
  input  wire logic                 ccr_h,
  input  wire logic                 ccr_i,
  input  wire logic                 irq_pin,
  // decode results
  output logic                      dec_valid,
  output logic                      dec_legal,
  output odrb_pkg::odrb_kind_t      dec_kind,
  output odrb_pkg::odrb_mode_t      dec_mode,
  output logic [1:0]                inst_len,
  output logic [3:0]                inst_cycles,
  output logic [15:0]               eff_addr,
  output logic                      branch_taken,
  output logic                      carry_wr,
  output logic                      carry_val,
  output logic                      bit_wr_en,
  output logic [7:0]                bit_wr_data
);

  // length in bytes of each addressing mode
  function automatic logic [1:0] mode_len(input odrb_pkg::odrb_mode_t m);
    case (m)
      odrb_pkg::M_IX:  mode_len = `ODRB_LEN_ONE;
      odrb_pkg::M_EXT: mode_len = `ODRB_LEN_THREE;
      odrb_pkg::M_IX2: mode_len = `ODRB_LEN_THREE;
      odrb_pkg::M_BTB: mode_len = `ODRB_LEN_THREE;
      default:         mode_len = `ODRB_LEN_TWO;
    endcase
  endfunction

  // base cycle count of a load-like access in each mode
  function automatic logic [3:0] mode_cyc(input odrb_pkg::odrb_mode_t m);
    case (m)
      odrb_pkg::M_IMM: mode_cyc = `ODRB_CYC_IMM;
      odrb_pkg::M_DIR: mode_cyc = `ODRB_CYC_DIR;
      odrb_pkg::M_EXT: mode_cyc = `ODRB_CYC_EXT;
      odrb_pkg::M_IX:  mode_cyc = `ODRB_CYC_IX;
      odrb_pkg::M_IX1: mode_cyc = `ODRB_CYC_IX1;
      odrb_pkg::M_IX2: mode_cyc = `ODRB_CYC_IX2;
      default:         mode_cyc = `ODRB_CYC_REL;
    endcase
  endfunction

  // condition of a relative branch from the low opcode nibble
  function automatic logic branch_cond(input logic [3:0] sel,
                                       input logic c, input logic z,
                                       input logic n, input logic h,
                                       input logic i, input logic pin);
    case (sel[3:1])
      3'h0: branch_cond = 1'b1;
      3'h1: branch_cond = ~(c | z);
      3'h2: branch_cond = ~c;
      3'h3: branch_cond = ~z;
      3'h4: branch_cond = ~h;
      3'h5: branch_cond = ~n;
      3'h6: branch_cond = ~i;
      default: branch_cond = ~pin;
    endcase
    // odd opcodes take the inverse sense
    branch_cond = branch_cond ^ sel[0];
  endfunction

  // register/memory operation from the low opcode nibble
  function automatic odrb_pkg::odrb_kind_t rm_kind(input logic [3:0] sel);
    case (sel)
      4'h0: rm_kind = odrb_pkg::K_SUB;
      4'h1: rm_kind = odrb_pkg::K_COMPARE_ACCUMULATOR_OP;
      4'h2: rm_kind = odrb_pkg::K_SUBTRACT_WITH_BORROW_OP;
      4'h3: rm_kind = odrb_pkg::K_COMPARE_INDEX_OP;
      4'h4: rm_kind = odrb_pkg::K_AND;
      4'h5: rm_kind = odrb_pkg::K_LOGIC_TEST;
      4'h6: rm_kind = odrb_pkg::K_LOAD_A;
      4'h7: rm_kind = odrb_pkg::K_STORE_ACCUMULATOR_OP;
      4'h8: rm_kind = odrb_pkg::K_EXCLUSIVE_OR_OP;
      4'h9: rm_kind = odrb_pkg::K_ADD_CARRY;
      4'ha: rm_kind = odrb_pkg::K_OR;
      4'hb: rm_kind = odrb_pkg::K_ADD;
      4'hc: rm_kind = odrb_pkg::K_JUMP_OP;
      4'hd: rm_kind = odrb_pkg::K_JUMP_TO_SUBROUTINE_OP;
      4'he: rm_kind = odrb_pkg::K_LOAD_X;
      default: rm_kind = odrb_pkg::K_STORE_INDEX_OP;
    endcase
  endfunction

  logic                 decode_en;
  logic [7:0]           op_last;
  logic [15:0]          dec_count;
  logic                 irq_s1;
  logic                 irq_s2;
  logic                 irq_s3;
  logic                 irq_level;
  logic                 accept;
  logic                 bus_req;
  logic [31:0]          next_rdata;
  odrb_pkg::odrb_kind_t next_kind;
  odrb_pkg::odrb_mode_t next_mode;
  logic [1:0]           next_len;
  logic [3:0]           next_cyc;
  logic                 next_legal;
  logic                 next_taken;
  logic [15:0]          next_ea;
  logic                 tested_bit;
  logic [7:0]           rewritten;

  assign accept  = dec_req & decode_en;
  assign bus_req = wb_cyc_i & wb_stb_i;

  // interrupt pin crosses in: three stages, level moves when last two agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_s1    <= 1'b1;
      irq_s2    <= 1'b1;
      irq_s3    <= 1'b1;
      irq_level <= 1'b1;
    end else begin
      irq_s1 <= irq_pin;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      if (irq_s2 == irq_s3) begin
        irq_level <= irq_s3;
      end
    end
  end

  // page 0 bit test and rewrite, n from opcode bits 3:1
  odrb_bit_unit u_bit (
    .byte_in       (mem_byte),
    .bit_sel       (opcode[3:1]),
    .clear_not_set (opcode[0]),
    .bit_val       (tested_bit),
    .byte_out      (rewritten)
  );

  // effective address for the decoded mode
  odrb_ea_calc u_ea (
    .mode      (next_mode),
    .op1       (operand1),
    .op2       (operand2),
    .index_val (index_reg),
    .ea        (next_ea)
  );

  // opcode group decode: lengths, cycles, kinds and branch decision
  always_comb begin
    next_kind  = odrb_pkg::K_OTHER;
    next_mode  = odrb_pkg::M_NONE;
    next_len   = `ODRB_LEN_ONE;
    next_cyc   = 4'h0;
    next_legal = 1'b0;
    next_taken = 1'b0;
    case (opcode[7:4])
      4'h0: begin
        next_kind  = opcode[0] ? odrb_pkg::K_TEST_BIT_BRANCH_IF_ZERO
                               : odrb_pkg::K_TEST_BIT_BRANCH_IF_ONE;
        next_mode  = odrb_pkg::M_BTB;
        next_len   = mode_len(odrb_pkg::M_BTB);
        next_cyc   = `ODRB_CYC_BIT;
        next_legal = 1'b1;
        next_taken = tested_bit ^ opcode[0];
      end
      4'h1: begin
        next_kind  = opcode[0] ? odrb_pkg::K_DIRECT_BIT_CLEAR
                               : odrb_pkg::K_DIRECT_BIT_SET;
        next_mode  = odrb_pkg::M_BSC;
        next_len   = mode_len(odrb_pkg::M_BSC);
        next_cyc   = `ODRB_CYC_BIT;
        next_legal = 1'b1;
      end
      4'h2: begin
        next_kind  = odrb_pkg::K_BRANCH;
        next_mode  = odrb_pkg::M_REL;
        next_len   = mode_len(odrb_pkg::M_REL);
        next_cyc   = `ODRB_CYC_REL;
        next_legal = 1'b1;
        next_taken = branch_cond(opcode[3:0], ccr_c, ccr_z, ccr_n,
                                 ccr_h, ccr_i, irq_level);
      end
      4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: begin
        case (opcode[7:4])
          4'ha:    next_mode = odrb_pkg::M_IMM;
          4'hb:    next_mode = odrb_pkg::M_DIR;
          4'hc:    next_mode = odrb_pkg::M_EXT;
          4'hd:    next_mode = odrb_pkg::M_IX2;
          4'he:    next_mode = odrb_pkg::M_IX1;
          default: next_mode = odrb_pkg::M_IX;
        endcase
        next_kind  = rm_kind(opcode[3:0]);
        next_len   = mode_len(next_mode);
        next_cyc   = mode_cyc(next_mode);
        next_legal = 1'b1;
        case (opcode[3:0])
          4'h7, 4'hf: next_cyc = mode_cyc(next_mode) + 4'h1;
          4'hc:       next_cyc = mode_cyc(next_mode) - 4'h1;
          4'hd:       next_cyc = mode_cyc(next_mode) + 4'h2;
          default:    next_cyc = mode_cyc(next_mode);
        endcase
        if (opcode == `ODRB_OP_CALL_REL) begin
          next_kind  = odrb_pkg::K_BRANCH_TO_SUBROUTINE;
          next_mode  = odrb_pkg::M_REL;
          next_len   = `ODRB_LEN_TWO;
          next_cyc   = `ODRB_CYC_CALL;
          next_taken = 1'b1;
        end else if (opcode[7:4] == 4'ha &&
                     (opcode[3:0] == 4'h7 || opcode[3:0] == 4'hc ||
                      opcode[3:0] == 4'hf)) begin
          // immediate slot holds no store or jump
          next_kind  = odrb_pkg::K_OTHER;
          next_mode  = odrb_pkg::M_NONE;
          next_len   = `ODRB_LEN_ONE;
          next_cyc   = 4'h0;
          next_legal = 1'b0;
        end
      end
      default: begin
        next_kind  = odrb_pkg::K_OTHER;
      end
    endcase
  end

  // decode results, loaded on each accepted request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dec_valid    <= 1'b0;
      dec_legal    <= 1'b0;
      dec_kind     <= odrb_pkg::K_OTHER;
      dec_mode     <= odrb_pkg::M_NONE;
      inst_len     <= 2'h0;
      inst_cycles  <= 4'h0;
      eff_addr     <= 16'h0000;
      branch_taken <= 1'b0;
      op_last      <= 8'h00;
    end else begin
      dec_valid <= accept;
      if (accept) begin
        dec_legal    <= next_legal;
        dec_kind     <= next_kind;
        dec_mode     <= next_mode;
        inst_len     <= next_len;
        inst_cycles  <= next_cyc;
        eff_addr     <= next_ea;
        branch_taken <= next_taken;
        op_last      <= opcode;
      end
    end
  end

  // carry copy and page 0 write pulses of the bit instructions
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      carry_wr    <= 1'b0;
      carry_val   <= 1'b0;
      bit_wr_en   <= 1'b0;
      bit_wr_data <= 8'h00;
    end else begin
      carry_wr  <= accept && opcode[7:4] == 4'h0;
      bit_wr_en <= accept && opcode[7:4] == 4'h1;
      if (accept && opcode[7:4] == 4'h0) begin
        carry_val <= tested_bit;
      end
      if (accept && opcode[7:4] == 4'h1) begin
        bit_wr_data <= rewritten;
      end
    end
  end

  // count of accepted decodes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dec_count <= 16'h0000;
    end else if (accept) begin
      dec_count <= dec_count + 16'h0001;
    end
  end

  // bus write to control, taken on the acknowledging edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      decode_en <= `ODRB_CTRL_RST;
    end else if (bus_req && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                 wb_adr_i == `ODRB_CTRL_OFS) begin
      decode_en <= wb_dat_i[`ODRB_CTRL_EN_BIT];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `ODRB_CTRL_OFS: next_rdata[`ODRB_CTRL_EN_BIT] = decode_en;
      `ODRB_STAT_OFS: begin
        next_rdata[`ODRB_STAT_OP_LSB +: 8]  = op_last;
        next_rdata[`ODRB_STAT_LEN_LSB +: 2] = inst_len;
        next_rdata[`ODRB_STAT_CYC_LSB +: 4] = inst_cycles;
        next_rdata[`ODRB_STAT_LEG_BIT]      = dec_legal;
        next_rdata[`ODRB_STAT_TKN_BIT]      = branch_taken;
      end
      `ODRB_CNT_OFS: next_rdata[15:0] = dec_count;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // one acknowledge per request, dropped the cycle after
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= next_rdata;
    end
  end

  // checks on the decode results
  a_carry_add_op: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && (opcode == 8'ha9 || opcode == 8'hc9 || opcode == 8'he9) |=>
    dec_kind == odrb_pkg::K_ADD_CARRY && inst_cycles ==
    (op_last == 8'ha9 ? 4'h2 : 4'h4))
    else $error("add with carry decode wrong");
  a_borrow_ix2: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && opcode == 8'hd2 |=> dec_valid && inst_len == 2'h3 &&
    inst_cycles == 4'h5 && eff_addr == {$past(operand1), $past(operand2)}
    + {8'h00, $past(index_reg)})
    else $error("borrow subtract indexed decode wrong");
  a_xor_noofs: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && opcode == 8'hf8 |=> inst_len == 2'h1 && inst_cycles == 4'h3
    && eff_addr == {8'h00, $past(index_reg)})
    else $error("exclusive or indexed decode wrong");
  a_cmp_index: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && opcode == 8'he3 |=> dec_kind == odrb_pkg::K_COMPARE_INDEX_OP
    && inst_len == 2'h2 && inst_cycles == 4'h4)
    else $error("index compare decode wrong");
  a_branch_timing: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    accept && opcode[7:4] == 4'h2 |=> dec_valid && inst_len == 2'h2 &&
    inst_cycles == 4'h3 && dec_kind == odrb_pkg::K_BRANCH)
    else $error("relative branch timing wrong");
  a_call_rel: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && opcode == 8'had |=> inst_cycles == 4'h6 && branch_taken)
    else $error("relative call decode wrong");
  a_lower_same: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && opcode == 8'h23 |=>
    branch_taken == ($past(ccr_c) | $past(ccr_z)))
    else $error("lower or same decision wrong");
  a_bit_carry: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && opcode[7:4] == 4'h0 |=> carry_wr &&
    carry_val == $past(tested_bit) &&
    branch_taken == ($past(tested_bit) ^ op_last[0]))
    else $error("bit test carry copy wrong");
  a_bit_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && opcode[7:4] == 4'h1 |=> bit_wr_en && inst_cycles == 4'h5
    && inst_len == 2'h2 && eff_addr == {8'h00, $past(operand1)})
    else $error("bit set or clear write wrong");
  a_no_imm_store: assert property (@(posedge core_clk) disable iff (sys_rst)
    accept && (opcode == 8'ha7 || opcode == 8'haf) |=> !dec_legal)
    else $error("immediate store slot decoded");

endmodule
`default_nettype wire

// [hdl/odrb_map.svh]
// offsets, field positions, reset values and timing counts of the decoder
`ifndef ODRB_MAP_SVH
`define ODRB_MAP_SVH
// register byte offsets on the bus
`define ODRB_CTRL_OFS     8'h00
`define ODRB_STAT_OFS     8'h04
`define ODRB_CNT_OFS      8'h08
// control register fields and reset value
`define ODRB_CTRL_EN_BIT  0
`define ODRB_CTRL_RST     1'b1
// status register field positions
`define ODRB_STAT_OP_LSB  0
`define ODRB_STAT_LEN_LSB 8
`define ODRB_STAT_CYC_LSB 10
`define ODRB_STAT_LEG_BIT 14
`define ODRB_STAT_TKN_BIT 15
// base cycle counts per addressing mode
`define ODRB_CYC_IMM      4'h2
`define ODRB_CYC_DIR      4'h3
`define ODRB_CYC_EXT      4'h4
`define ODRB_CYC_IX       4'h3
`define ODRB_CYC_IX1      4'h4
`define ODRB_CYC_IX2      4'h5
`define ODRB_CYC_REL      4'h3
`define ODRB_CYC_CALL     4'h6
`define ODRB_CYC_BIT      4'h5
// instruction lengths in bytes
`define ODRB_LEN_ONE      2'h1
`define ODRB_LEN_TWO      2'h2
`define ODRB_LEN_THREE    2'h3
// special encodings
`define ODRB_OP_CALL_REL  8'had
`define ODRB_PAGE0_HI     8'h00
`endif

// [hdl/odrb_pkg.sv]
// types shared by the decoder modules
`default_nettype none
package odrb_pkg;
  // addressing modes
  typedef enum logic [3:0] {
    M_NONE, M_IMM, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_REL, M_BSC, M_BTB
  } odrb_mode_t;
  // operation kinds covered by this decoder
  typedef enum logic [4:0] {
    K_OTHER, K_ADD_CARRY, K_SUBTRACT_WITH_BORROW_OP, K_EXCLUSIVE_OR_OP,
    K_COMPARE_ACCUMULATOR_OP, K_COMPARE_INDEX_OP, K_LOGIC_TEST,
    K_LOAD_A, K_LOAD_X, K_STORE_ACCUMULATOR_OP, K_STORE_INDEX_OP,
    K_ADD, K_SUB, K_AND, K_OR, K_JUMP_OP, K_JUMP_TO_SUBROUTINE_OP,
    K_BRANCH, K_BRANCH_TO_SUBROUTINE, K_TEST_BIT_BRANCH_IF_ONE,
    K_TEST_BIT_BRANCH_IF_ZERO, K_DIRECT_BIT_SET, K_DIRECT_BIT_CLEAR
  } odrb_kind_t;
endpackage
`default_nettype wire

// [hdl/odrb_ea_calc.sv]
// effective address former for direct, extended and indexed modes
`include "odrb_map.svh"
`default_nettype none
module odrb_ea_calc (
  input  wire odrb_pkg::odrb_mode_t mode,
  input  wire logic [7:0]           op1,
  input  wire logic [7:0]           op2,
  input  wire logic [7:0]           index_val,
  output logic [15:0]               ea
);
  // unsigned index plus zero, 8-bit or 16-bit offset
  always_comb begin
    case (mode)
      odrb_pkg::M_DIR: ea = {`ODRB_PAGE0_HI, op1};
      odrb_pkg::M_BSC: ea = {`ODRB_PAGE0_HI, op1};
      odrb_pkg::M_BTB: ea = {`ODRB_PAGE0_HI, op1};
      odrb_pkg::M_EXT: ea = {op1, op2};
      odrb_pkg::M_IX:  ea = {8'h00, index_val};
      odrb_pkg::M_IX1: ea = {8'h00, op1} + {8'h00, index_val};
      odrb_pkg::M_IX2: ea = {op1, op2} + {8'h00, index_val};
      default:         ea = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

// [hdl/odrb_bit_unit.sv]
// selects, tests and rewrites one bit of a direct page byte
`default_nettype none
module odrb_bit_unit (
  input  wire logic [7:0] byte_in,
  input  wire logic [2:0] bit_sel,
  input  wire logic       clear_not_set,
  output logic            bit_val,
  output logic [7:0]      byte_out
);
  // bit picked by n, and the byte with that bit forced
  always_comb begin
    bit_val  = byte_in[bit_sel];
    byte_out = byte_in;
    byte_out[bit_sel] = ~clear_not_set;
  end
endmodule
`default_nettype wire

// [test/odrb_mem_model.sv]
// page-0 data memory model answering the decoder's byte reads and writes
`default_nettype none
module odrb_mem_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] rd_addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  output logic [7:0]      rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  // known start pattern, so bit tests have fixed expectations
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // write back of bit set/clear; one-byte address covers page 0 only
  always @(posedge core_clk) begin
    if (wr_en) mem[wr_addr] <= wr_data;
  end
  assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire

// [test/test_opcode_decode_regmem_branch_bit.sv]
// bench: bus and decode calls compared against expected results
`default_nettype none
module test_opcode_decode_regmem_branch_bit;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00, op = 8'h00, o1 = 8'h00, o2 = 8'h00, x = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, req = 1'b0, c = 1'b0, z = 1'b0, h = 1'b0, i = 1'b0;
  logic        pin = 1'b1, vld, lgl, tkn, cwr, cv, bwe;
  logic [7:0]  mb, bwd, b, m;
  logic [1:0]  len;
  logic [3:0]  cy;
  logic [15:0] ea;
  odrb_pkg::odrb_kind_t kind;
  odrb_pkg::odrb_mode_t mode;
  int miscompares = 0, check_count = 0, acc = 0;
  logic [15:0] tab [19] = '{16'ha922, 16'hc934, 16'he924, 16'ha222,
    16'hc234, 16'hd235, 16'ha822, 16'hc834, 16'hf813, 16'ha122, 16'hc134,
    16'hd135, 16'hf313, 16'he324, 16'hd335, 16'ha522, 16'hc534, 16'hf513,
    16'had26};
  odrb_pkg::odrb_kind_t kt [7] = '{odrb_pkg::K_ADD_CARRY,
    odrb_pkg::K_SUBTRACT_WITH_BORROW_OP, odrb_pkg::K_EXCLUSIVE_OR_OP,
    odrb_pkg::K_COMPARE_ACCUMULATOR_OP, odrb_pkg::K_COMPARE_INDEX_OP,
    odrb_pkg::K_LOGIC_TEST, odrb_pkg::K_BRANCH_TO_SUBROUTINE};
  // 25 ns clock
  always #12.5 clk = ~clk;
  odrb_decoder dut_u (.core_clk(clk), .sys_rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dec_req(req),
    .opcode(op), .operand1(o1), .operand2(o2), .index_reg(x),
    .mem_byte(mb), .ccr_c(c), .ccr_z(z), .ccr_n(1'b0), .ccr_h(h),
    .ccr_i(i), .irq_pin(pin), .dec_valid(vld), .dec_legal(lgl),
    .dec_kind(kind), .dec_mode(mode), .inst_len(len), .inst_cycles(cy),
    .eff_addr(ea), .branch_taken(tkn), .carry_wr(cwr), .carry_val(cv),
    .bit_wr_en(bwe), .bit_wr_data(bwd));
  odrb_mem_model mem_u (.core_clk(clk), .rd_addr(o1), .wr_en(bwe),
    .wr_addr(ea[7:0]), .wr_data(bwd), .rd_data(mb));
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic wishbone single cycle, results sampled at the ack edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(32'(ack), 32'h1);
    if (ack !== 1'b1) end_sim;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask
  // one decode request; want tells whether a valid answer is expected
  task dec(input logic [7:0] p, input logic [7:0] a, input logic want);
    int n;
    n = 0;
    req <= 1'b1; op <= p; o1 <= a; o2 <= 8'h34;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (vld !== 1'b1 && n < 4);
    chk(32'(vld), 32'(want));
    if (vld !== want) end_sim;
    if (want) acc++;
  endtask
  task br(input logic [7:0] p, input logic t);
    dec(p, 8'h00, 1'b1);
    chk({len, cy, tkn}, {2'h2, 4'h3, t});
  endtask
  task end_sim;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // register reset values and an unmapped place
    wb(0, 8'h00, 0); chk(q, 1);
    wb(0, 8'h04, 0); chk(q, 0);
    wb(0, 8'h08, 0); chk(q, 0);
    wb(0, 8'h0c, 0); chk(q, 0);
    // opcode table: length, cycles and kind, one request every other cycle
    x <= 8'h05;
    for (int k = 0; k < 19; k++) begin
      dec(tab[k][15:8], 8'h12, 1'b1);
      chk({lgl, len, cy}, {1'b1, tab[k][5:4], tab[k][3:0]});
      chk(32'(kind), 32'(kt[k / 3]));
    end
    // indexed effective addresses
    dec(8'hd2, 8'h12, 1'b1); chk(ea, 16'h1239);
    chk(32'(mode), 32'(odrb_pkg::M_IX2));
    wb(0, 8'h04, 0); chk(q, 32'h57d2);
    x <= 8'hff;
    dec(8'he9, 8'hff, 1'b1); chk(ea, 16'h01fe);
    x <= 8'h80;
    dec(8'hf8, 8'h77, 1'b1); chk(ea, 16'h0080);
    // immediate slots of store, store index and jump
    dec(8'ha7, 8'h00, 1'b1); chk(lgl, 0);
    dec(8'haf, 8'h00, 1'b1); chk(lgl, 0);
    dec(8'hac, 8'h00, 1'b1); chk(lgl, 0);
    // conditional branches
    br(8'h23, 0); br(8'h24, 1);
    c <= 1'b1;
    br(8'h23, 1); br(8'h24, 0);
    c <= 1'b0; z <= 1'b1;
    br(8'h23, 1);
    br(8'h28, 1); br(8'h29, 0);
    h <= 1'b1;
    br(8'h28, 0); br(8'h29, 1);
    br(8'h2c, 1); br(8'h2d, 0);
    i <= 1'b1;
    br(8'h2c, 0); br(8'h2d, 1);
    br(8'h2e, 0); br(8'h2f, 1);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
    br(8'h2e, 1); br(8'h2f, 0);
    // set, test, clear, test each bit of its own page-0 byte
    for (int n = 0; n < 8; n++) begin
      b = 8'(8'h40 + n) ^ 8'h5a;
      m = 8'h01 << n;
      dec(8'(8'h10 + 2 * n), 8'(8'h40 + n), 1'b1);
      chk({bwe, bwd, ea}, {1'b1, b | m, 16'(8'h40 + n)});
      dec(8'(2 * n), 8'(8'h40 + n), 1'b1);
      chk({len, cy, tkn, cwr, cv}, {2'h3, 4'h5, 3'b111});
      dec(8'(8'h11 + 2 * n), 8'(8'h40 + n), 1'b1);
      chk({bwe, bwd}, {1'b1, b & ~m});
      dec(8'(8'h01 + 2 * n), 8'(8'h40 + n), 1'b1);
      chk({len, cy, tkn, cwr, cv}, {2'h3, 4'h5, 3'b110});
      dec(8'(2 * n), 8'(8'h40 + n), 1'b1);
      chk({tkn, cwr, cv}, 3'b010);
    end
    // disabled decoder refuses, count shows accepted decodes only
    wb(1, 8'h00, 0);
    dec(8'ha9, 8'h00, 1'b0);
    wb(0, 8'h08, 0); chk(q, acc);
    wb(1, 8'h00, 1);
    dec(8'ha9, 8'h00, 1'b1);
    end_sim;
  end
endmodule
`default_nettype wire
